/* File: bench/cdsr_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cdsr_engine_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic test_start,
  input wire logic test_busy,
  input wire logic [7:0] dly,
  input wire logic [1:0] fault_in,
  input wire logic [7:0] data_in,
  output logic test_done,
  output logic [1:0] cable_fault_status,
  output logic [7:0] cable_result_value
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cnt_reg <= 8'h00;
    else if (test_start) cnt_reg <= dly;
    else if (!test_busy) cnt_reg <= 8'h00;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  assign test_done = test_busy && cnt_reg == 8'h01;
  // results only valid in the done cycle, junk otherwise
  assign cable_fault_status = test_done ? fault_in : ~fault_in;
  assign cable_result_value = test_done ? data_in : ~data_in;
endmodule : cdsr_engine_model
`default_nettype wire

/* File: bench/cdsr_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module cdsr_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic test_start,
  input wire logic test_abort,
  input wire logic test_busy,
  input wire logic tx_disable,
  input wire logic [1:0] test_pair_select,
  input wire logic [9:0] hi_thresh,
  input wire logic [9:0] lo_thresh,
  input wire logic test_done,
  input wire logic link_1000_ok,
  input wire logic link_100_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic cw;
  assign cw = mgmt_wr && mgmt_addr == 5'h12;
  chk_run_start: assert property (cw && mgmt_wdata[15] && !test_busy |=> test_start && test_busy)
    else $error("start missed");
  chk_done_clears: assert property (test_busy && test_done |=> !test_busy)
    else $error("busy stuck");
  chk_abort_stop: assert property (cw && !mgmt_wdata[15] && test_busy |=> test_abort && !test_busy)
    else $error("abort missed");
  chk_busy_read: assert property (mgmt_rd && mgmt_addr == 5'h12 |=> mgmt_rdata[15] == $past(test_busy))
    else $error("run bit wrong");
  chk_hold_follow: assert property (cw |=> ##1 tx_disable == $past(mgmt_wdata[14], 2))
    else $error("hold wrong");
  chk_pair_follow: assert property (cw |=> test_pair_select == $past(mgmt_wdata[13:12]))
    else $error("pair wrong");
  chk_thresh_fixed: assert property (hi_thresh == 10'h040 && lo_thresh == 10'h3c0)
    else $error("threshold wrong");
  chk_link_read: assert property (mgmt_rd && mgmt_addr == 5'h13 |=>
    mgmt_rdata[1:0] == {$past(link_1000_ok, 2), $past(link_100_ok, 2)})
    else $error("link bits wrong");
endmodule : cdsr_chk
bind cdsr_regs cdsr_chk chk_u (.clk, .reset, .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata,
  .mgmt_rdata, .test_start, .test_abort, .test_busy, .tx_disable, .test_pair_select,
  .hi_thresh, .lo_thresh, .test_done, .link_1000_ok, .link_100_ok);
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, reset = 1, mgmt_wr = 0, mgmt_rd = 0, rd_d = 0, rx_error = 0;
  logic link_1000_ok = 0, link_100_ok = 0, test_start, test_abort, test_busy, tx_disable, test_done;
  logic [4:0] mgmt_addr = 0;
  logic [15:0] mgmt_wdata = 0, mgmt_rdata, got;
  logic [1:0] test_pair_select, fs, fault_in = 0, lf = 0;
  logic [9:0] hi_thresh, lo_thresh;
  logic [7:0] rv, data_in = 0, ld = 0, dly = 8'd6;
  logic [15:0] q[$];
  logic [31:0] seed = 32'hae6bcc56;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #12.5 clk = ~clk;
  cdsr_regs dut_u (.clk, .reset, .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata, .mgmt_rdata,
    .test_start, .test_abort, .test_busy, .tx_disable, .test_pair_select, .hi_thresh,
    .lo_thresh, .test_done, .cable_fault_status(fs), .cable_result_value(rv), .link_1000_ok,
    .link_100_ok, .rx_error);
  cdsr_engine_model eng_u (.clk, .reset, .test_start, .test_busy, .dly, .fault_in, .data_in,
    .test_done, .cable_fault_status(fs), .cable_result_value(rv));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] cw(input logic [5:0] t, input logic [1:0] f,
    input logic [7:0] d);
    case (t[1:0])
      2'h0: return {t, f, d};
      2'h1: return {t, 10'h040};
      2'h2: return {t, 10'h3c0};
      default: return {t, 10'h000};
    endcase
  endfunction : cw
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_wr = 1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(negedge clk);
    mgmt_wr = 0;
  endtask : wr
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk);
    mgmt_rd = 1;
    mgmt_addr = a;
    q.push_back(e);
    @(negedge clk);
    mgmt_rd = 0;
  endtask : rd
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) rd_d <= mgmt_rd;
  always @(negedge clk) begin
    if (rd_d) begin
      got = q.pop_front();
      n_tests++;
      if (mgmt_rdata !== got) begin
        err_count++;
        $display("mismatch mgmt_rdata expected %h seen %h", got, mgmt_rdata);
      end
    end
  end
  // long enough for the saturation run plus margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) reset = 0;
    rd(5'h12, 16'h0000);
    rd(5'h15, 16'h0000);
    rd(5'h1f, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      {link_1000_ok, link_100_ok} = seed[1:0];
      rd(5'h13, {14'h0, seed[1:0]});
      fault_in = 2'(i);
      data_in = seed[15:8];
      wr(5'h12, {2'b10, 2'(i), 12'h000});
      rd(5'h12, cw({2'b10, 2'(i), 2'b00}, lf, ld));
      repeat (12) @(negedge clk);
      lf = 2'(i);
      ld = seed[15:8];
      rd(5'h12, cw({2'b00, 2'(i), 2'b00}, lf, ld));
    end
    for (int v = 1; v < 4; v++) begin
      wr(5'h12, {4'b0011, 2'(v), 10'h3ff});
      rd(5'h12, cw({4'b0011, 2'(v)}, lf, ld));
    end
    wr(5'h12, 16'h4000);
    rd(5'h12, cw(6'b010000, lf, ld));
    dly = 8'd50;
    wr(5'h12, 16'h8000);
    wr(5'h12, 16'h0000);
    repeat (60) @(negedge clk);
    rd(5'h12, cw(6'b000000, lf, ld));
    wr(5'h15, 16'hffff);
    rx_error = 1;
    repeat (3) @(negedge clk);
    rd(5'h15, 16'h0004);
    rx_error = 0;
    rd(5'h15, 16'h0001);
    rx_error = 1;
    repeat (65540) @(negedge clk);
    rx_error = 0;
    rd(5'h15, 16'hffff);
    rd(5'h15, 16'h0000);
    repeat (3) @(negedge clk);
    complete_run;
  end
endmodule : tb_top
`default_nettype wire

/* File: hw/cdsr_consts.svh */
`ifndef CDSR_CONSTS_SVH
`define CDSR_CONSTS_SVH

`define CDSR_ADDR_CABLE 5'h12
`define CDSR_ADDR_LINK 5'h13
`define CDSR_ADDR_RXERR 5'h15

`define CDSR_RUN_BIT 15
`define CDSR_HOLD_BIT 14
`define CDSR_PAIR_HI 13
`define CDSR_PAIR_LO 12
`define CDSR_VIEW_HI 11
`define CDSR_VIEW_LO 10

`define CDSR_HI_THRESH_RST 10'h040
`define CDSR_LO_THRESH_RST 10'h3c0
`define CDSR_RXERR_MAX 16'hffff

`endif

/* File: hw/cdsr_pkg.sv */
package cdsr_pkg;

  typedef enum logic [1:0] {
    CDSR_VIEW_RESULT,
    CDSR_VIEW_HI_THRESH,
    CDSR_VIEW_LO_THRESH,
    CDSR_VIEW_RSVD
  } cdsr_view_t;

  typedef enum logic [1:0] {
    CDSR_FAULT_NONE,
    CDSR_FAULT_OPEN,
    CDSR_FAULT_SHORT,
    CDSR_FAULT_FAILED
  } cdsr_fault_t;

  typedef enum {
    CDSR_ST_IDLE,
    CDSR_ST_RUN
  } cdsr_state_t;

endpackage : cdsr_pkg

/* File: hw/cdsr_regs.sv */
// Behaviour
// RL1 - writing one to bit 15 starts a cable test on the selected pair
// RL2 - test-run bit clears itself when the measurement finishes
// RL3 - writing zero to test-run aborts a running test
// RL4 - test-run reads one while running, zero when results valid
// RL5 - transmit-hold bit one disables transmitter and holds the diagnostic
// RL6 - bits 13:12 pick pair A, B, C or D for the test
// RL7 - bits 11:10 select result, high threshold or low threshold in bits 9:0
// RL8 - high pulse threshold defaults to 64, shown at view 01
// RL9 - low pulse threshold defaults to minus 64, shown at view 10
// RL10 - bits 9:8 give fault status: none, open, short, failed
// RL11 - bits 7:0 carry result data whose meaning follows fault status
// RL12 - controller computes distance as 0.8 times data minus 22
// RL13 - failed test sets data bit 7 for invalid reflected pulse width
// RL14 - failed test flags long signal, high-frequency and fast-pulse reasons
// RL15 - failed test reports low and high pulse counts saturated at 3
// RL16 - link status bit 1 shows gigabit link good, resets zero
// RL17 - link status bit 0 shows 100 Mb/s link good, resets zero
// RL18 - 16-bit receive error counter, reset zero, cleared on read
// RL19 - receive error counter saturates at 0xffff
// RL20 - read returns pre-clear value; error in clear cycle counts one
`include "cdsr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module cdsr_regs (
  input wire logic clk,
  input wire logic reset,
  // management access, one cycle strobes
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // analog measurement engine
  output logic test_start,
  output logic test_abort,
  output logic test_busy,
  output logic tx_disable,
  output logic [1:0] test_pair_select,
  output logic [9:0] hi_thresh,
  output logic [9:0] lo_thresh,
  input wire logic test_done,
  input wire logic [1:0] cable_fault_status,
  input wire logic [7:0] cable_result_value,
  // link and receive error inputs
  input wire logic link_1000_ok,
  input wire logic link_100_ok,
  input wire logic rx_error
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  logic wr_cable;
  logic rd_rxerr;
  assign wr_cable = mgmt_wr && hit(mgmt_addr, `CDSR_ADDR_CABLE);
  assign rd_rxerr = mgmt_rd && hit(mgmt_addr, `CDSR_ADDR_RXERR);

  cdsr_pkg::cdsr_state_t state_reg;
  logic hold_reg;
  logic [1:0] view_reg;
  logic [1:0] fault_reg;
  logic [7:0] data_reg;
  logic [1:0] link_reg;
  logic [15:0] rxerr_reg;
  logic [15:0] rxerr_next;

  ////////////////////////////////////////////////////////////////////////////
  // test sequencing

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= cdsr_pkg::CDSR_ST_IDLE;
      test_start <= 1'b0;
      test_abort <= 1'b0;
    end else begin
      test_start <= 1'b0;
      test_abort <= 1'b0;
      case (state_reg)
        cdsr_pkg::CDSR_ST_IDLE: begin
          if (wr_cable && mgmt_wdata[`CDSR_RUN_BIT]) begin
            state_reg <= cdsr_pkg::CDSR_ST_RUN; // RL1
            test_start <= 1'b1; // RL1
          end
        end
        cdsr_pkg::CDSR_ST_RUN: begin
          if (wr_cable && !mgmt_wdata[`CDSR_RUN_BIT]) begin
            state_reg <= cdsr_pkg::CDSR_ST_IDLE; // RL3
            test_abort <= 1'b1; // RL3
          end else if (test_done) begin
            state_reg <= cdsr_pkg::CDSR_ST_IDLE; // RL2
          end
        end
        default: state_reg <= cdsr_pkg::CDSR_ST_IDLE;
      endcase
    end
  end

  // busy mirrors the run state so the read-back bit and engine agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      test_busy <= 1'b0;
    end else if (state_reg == cdsr_pkg::CDSR_ST_IDLE) begin
      test_busy <= wr_cable && mgmt_wdata[`CDSR_RUN_BIT]; // RL4
    end else begin
      test_busy <= !(test_done || (wr_cable && !mgmt_wdata[`CDSR_RUN_BIT])); // RL4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_reg <= 1'b0;
      test_pair_select <= 2'h0;
      view_reg <= 2'h0;
    end else if (wr_cable) begin
      hold_reg <= mgmt_wdata[`CDSR_HOLD_BIT]; // RL5
      test_pair_select <= mgmt_wdata[`CDSR_PAIR_HI:`CDSR_PAIR_LO]; // RL6
      view_reg <= mgmt_wdata[`CDSR_VIEW_HI:`CDSR_VIEW_LO]; // RL7
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_disable <= 1'b0;
    end else begin
      tx_disable <= hold_reg; // RL5
    end
  end

  // thresholds are presented only; writes to bits 9:0 are ignored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_thresh <= `CDSR_HI_THRESH_RST; // RL8
      lo_thresh <= `CDSR_LO_THRESH_RST; // RL9
    end else begin
      hi_thresh <= `CDSR_HI_THRESH_RST; // RL8
      lo_thresh <= `CDSR_LO_THRESH_RST; // RL9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results, captured at completion so they stay stable while polled

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_reg <= 2'h0;
      data_reg <= 8'h00;
    end else if (state_reg == cdsr_pkg::CDSR_ST_RUN && test_done &&
                 !(wr_cable && !mgmt_wdata[`CDSR_RUN_BIT])) begin
      fault_reg <= cable_fault_status; // RL10
      data_reg <= cable_result_value; // RL11 RL13 RL14 RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link status

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_reg <= 2'h0;
    end else begin
      link_reg <= {link_1000_ok, link_100_ok}; // RL16 RL17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive error counter

  always_comb begin
    if (rd_rxerr) begin
      rxerr_next = {15'h0000, rx_error}; // RL18 RL20
    end else if (rx_error && rxerr_reg != `CDSR_RXERR_MAX) begin
      rxerr_next = rxerr_reg + 16'h0001; // RL19
    end else begin
      rxerr_next = rxerr_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxerr_reg <= 16'h0000; // RL18
    end else begin
      rxerr_reg <= rxerr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the strobe

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      case (mgmt_addr)
        `CDSR_ADDR_CABLE: begin
          case (view_reg)
            cdsr_pkg::CDSR_VIEW_RESULT:
              mgmt_rdata <= {test_busy, hold_reg, test_pair_select, view_reg,
                             fault_reg, data_reg}; // RL4 RL7 RL10 RL11
            cdsr_pkg::CDSR_VIEW_HI_THRESH:
              mgmt_rdata <= {test_busy, hold_reg, test_pair_select, view_reg,
                             hi_thresh}; // RL8
            cdsr_pkg::CDSR_VIEW_LO_THRESH:
              mgmt_rdata <= {test_busy, hold_reg, test_pair_select, view_reg,
                             lo_thresh}; // RL9
            default:
              mgmt_rdata <= {test_busy, hold_reg, test_pair_select, view_reg, 10'h000};
          endcase
        end
        `CDSR_ADDR_LINK: mgmt_rdata <= {14'h0000, link_reg}; // RL16 RL17
        `CDSR_ADDR_RXERR: mgmt_rdata <= rxerr_reg; // RL20
        default: mgmt_rdata <= 16'h0000;
      endcase
    end
  end

endmodule : cdsr_regs

`default_nettype wire
